// >>> rtl/mgmt_crossbar_pkg.sv
// management crossbar constants, limits and the queued operation layout
// assumes every initiator and target block runs on the one management clock
package mgmt_crossbar_pkg;

	// ------------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------------
	localparam int NUM_PORTS = 12;
	localparam int ID_W = 4;
	localparam int DW = 32;
	localparam int WIDE_WORDS = 4;
	localparam int WIDE_W = WIDE_WORDS * DW;
	localparam int CNT_W = 2;
	localparam int FIFO_DEPTH = 2;
	localparam int NUM_SLOTS = 5;
	localparam int LIM_W = 3;

	// ------------------------------------------------------------------
	// per-target concurrency limits
	// ------------------------------------------------------------------
	localparam logic [LIM_W-1:0] DEFAULT_LIMIT = 3'h4;
	localparam logic [LIM_W-1:0] FRAME_MGR_LIMIT = 3'h5;
	localparam logic [LIM_W-1:0] RATE_MON_LIMIT = 3'h3;
	localparam int FRAME_MGR_PORT = 6;
	localparam int RATE_MON_PORT = 0;

	function automatic logic [LIM_W-1:0] tgt_limit(input int t);
		if (t == FRAME_MGR_PORT)
			return FRAME_MGR_LIMIT;
		else if (t == RATE_MON_PORT)
			return RATE_MON_LIMIT;
		return DEFAULT_LIMIT;
	endfunction

	// ------------------------------------------------------------------
	// one queued operation toward a target
	// ------------------------------------------------------------------
	typedef struct packed {
		logic write;
		logic [ID_W-1:0] src;
		logic [CNT_W-1:0] words;
		logic [DW-1:0] addr;
		logic [WIDE_W-1:0] data;
	} op_entry_t;

endpackage

// >>> rtl/mgmt_crossbar.sv
// management crossbar: 12 initiator ports to 12 target front ends
// assumes targets answer reads in the order they popped them, and that an
// initiator holds its request stable until it sees its acknowledge pulse
//
// What this block does
// - twelve by twelve matrix; distinct pairs move in the same cycle.
// - each target serves up to four initiators at once by default.
// - frame handler manager target serves five; rate monitor target three.
// - only reads and writes; each read answer goes back to its issuer.
// - wider-than-32-bit writes gather in scratch, then commit as one.
// - a scratch set per served initiator; rate monitor target has three.
// - each target has a small queue; full queue pushes back.
// - initiator to a full target is stalled and holds its operation.
`timescale 1ns/1ps

module mgmt_crossbar
	import mgmt_crossbar_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [NUM_PORTS-1:0] i_req_valid,
	input wire logic [NUM_PORTS-1:0] i_req_write,
	input wire logic [NUM_PORTS-1:0] i_req_last,
	input wire logic [NUM_PORTS-1:0][ID_W-1:0] i_req_tgt,
	input wire logic [NUM_PORTS-1:0][DW-1:0] i_req_addr,
	input wire logic [NUM_PORTS-1:0][DW-1:0] i_req_wdata,
	output logic [NUM_PORTS-1:0] o_req_ack,
	output logic [NUM_PORTS-1:0] o_rsp_valid,
	output logic [NUM_PORTS-1:0][WIDE_W-1:0] o_rsp_rdata,
	output logic [NUM_PORTS-1:0] o_tgt_valid,
	output logic [NUM_PORTS-1:0] o_tgt_write,
	output logic [NUM_PORTS-1:0][ID_W-1:0] o_tgt_src,
	output logic [NUM_PORTS-1:0][CNT_W-1:0] o_tgt_words,
	output logic [NUM_PORTS-1:0][DW-1:0] o_tgt_addr,
	output logic [NUM_PORTS-1:0][WIDE_W-1:0] o_tgt_wdata,
	input wire logic [NUM_PORTS-1:0] i_tgt_ready,
	input wire logic [NUM_PORTS-1:0] i_tgt_rsp_valid,
	input wire logic [NUM_PORTS-1:0][ID_W-1:0] i_tgt_rsp_src,
	input wire logic [NUM_PORTS-1:0][WIDE_W-1:0] i_tgt_rsp_rdata
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [NUM_PORTS-1:0][FIFO_DEPTH-1:0] fifo_vld;
		op_entry_t [NUM_PORTS-1:0][FIFO_DEPTH-1:0] fifo_ent;
		logic [NUM_PORTS-1:0][NUM_SLOTS-1:0] slot_vld;
		logic [NUM_PORTS-1:0][NUM_SLOTS-1:0][ID_W-1:0] slot_own;
		logic [NUM_PORTS-1:0][NUM_SLOTS-1:0][CNT_W-1:0] slot_cnt;
		logic [NUM_PORTS-1:0][NUM_SLOTS-1:0][WIDE_WORDS-2:0][DW-1:0] slot_dat;
		logic [NUM_PORTS-1:0][ID_W-1:0] rr_last;
		logic [NUM_PORTS-1:0] rd_pend;
		logic [NUM_PORTS-1:0][ID_W-1:0] rd_tgt;
		logic [NUM_PORTS-1:0] ack;
		logic [NUM_PORTS-1:0] rsp_vld;
		logic [NUM_PORTS-1:0][WIDE_W-1:0] rsp_dat;
	} xbar_state_t;

	xbar_state_t st_r;
	xbar_state_t st_nxt;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb
	begin
		int idx;
		int hit;
		int fre;
		int used;
		int cnt;
		int pos;
		logic granted;
		logic partial;
		logic elig;
		op_entry_t ent;
		idx = 0;
		hit = -1;
		fre = -1;
		used = 0;
		cnt = 0;
		pos = 0;
		granted = 1'b0;
		partial = 1'b0;
		elig = 1'b0;
		ent = '0;
		st_nxt = st_r;
		st_nxt.ack = '0;
		st_nxt.rsp_vld = '0;

		// read answers routed back by the tag the target returns
		for (int t = 0; t < NUM_PORTS; t++)
		begin
			if (i_tgt_rsp_valid[t])
			begin
				st_nxt.rsp_vld[i_tgt_rsp_src[t]] = 1'b1;
				st_nxt.rsp_dat[i_tgt_rsp_src[t]] = i_tgt_rsp_rdata[t];
				st_nxt.rd_pend[i_tgt_rsp_src[t]] = 1'b0;
			end
		end

		// every target arbitrates on its own, so pairs with different targets run at once
		for (int t = 0; t < NUM_PORTS; t++)
		begin
			if (st_nxt.fifo_vld[t][0] && i_tgt_ready[t])
			begin
				for (int d = 0; d < FIFO_DEPTH - 1; d++)
				begin
					st_nxt.fifo_vld[t][d] = st_nxt.fifo_vld[t][d+1];
					st_nxt.fifo_ent[t][d] = st_nxt.fifo_ent[t][d+1];
				end
				st_nxt.fifo_vld[t][FIFO_DEPTH-1] = 1'b0;
			end
			used = 0;
			for (int s = 0; s < NUM_SLOTS; s++)
				if (st_nxt.slot_vld[t][s])
					used++;
			granted = 1'b0;
			for (int k = 0; k < NUM_PORTS; k++)
			begin
				idx = (int'(st_r.rr_last[t]) + 1 + k) % NUM_PORTS;
				hit = -1;
				fre = -1;
				for (int s = 0; s < NUM_SLOTS; s++)
				begin
					if (st_nxt.slot_vld[t][s] &&
						st_nxt.slot_own[t][s] == ID_W'(idx))
						hit = s;
					else if (!st_nxt.slot_vld[t][s] && fre < 0 &&
						s < int'(tgt_limit(t)))
						fre = s;
				end
				cnt = (hit >= 0) ? int'(st_nxt.slot_cnt[t][hit]) : 0;
				partial = i_req_write[idx] && !i_req_last[idx] &&
					cnt < WIDE_WORDS - 1;
				// a stalled initiator just sees no acknowledge
				elig = !granted && i_req_valid[idx] &&
					i_req_tgt[idx] == ID_W'(t) &&
					!st_r.ack[idx] && !st_r.rd_pend[idx] &&
					(partial || !st_nxt.fifo_vld[t][FIFO_DEPTH-1]) &&
					(hit >= 0 || (fre >= 0 &&
					used < int'(tgt_limit(t))));
				if (elig)
				begin
					granted = 1'b1;
					if (hit < 0)
					begin
						hit = fre;
						st_nxt.slot_vld[t][hit] = 1'b1;
						st_nxt.slot_own[t][hit] = ID_W'(idx);
						st_nxt.slot_cnt[t][hit] = '0;
					end
					st_nxt.ack[idx] = 1'b1;
					st_nxt.rr_last[t] = ID_W'(idx);
					if (partial)
					begin
						st_nxt.slot_dat[t][hit][cnt] = i_req_wdata[idx];
						st_nxt.slot_cnt[t][hit] = CNT_W'(cnt + 1);
					end
					else
					begin
						ent = '0;
						ent.write = i_req_write[idx];
						ent.src = ID_W'(idx);
						ent.addr = i_req_addr[idx];
						if (i_req_write[idx])
						begin
							// the whole entry leaves in one queue slot
							for (int w = 0; w < WIDE_WORDS - 1; w++)
								if (w < cnt)
									ent.data[w*DW +: DW] = st_nxt.slot_dat[t][hit][w];
							ent.data[cnt*DW +: DW] = i_req_wdata[idx];
							ent.words = CNT_W'(cnt);
							st_nxt.slot_cnt[t][hit] = '0;
						end
						else
						begin
							// one read in flight per initiator keeps order
							st_nxt.rd_pend[idx] = 1'b1;
							st_nxt.rd_tgt[idx] = ID_W'(t);
						end
						pos = FIFO_DEPTH;
						for (int d = FIFO_DEPTH - 1; d >= 0; d--)
							if (!st_nxt.fifo_vld[t][d])
								pos = d;
						if (pos < FIFO_DEPTH)
						begin
							st_nxt.fifo_vld[t][pos] = 1'b1;
							st_nxt.fifo_ent[t][pos] = ent;
						end
					end
				end
			end
		end

		// a slot is given up once it holds no partial data and no read
		for (int t = 0; t < NUM_PORTS; t++)
			for (int s = 0; s < NUM_SLOTS; s++)
				if (st_nxt.slot_vld[t][s] && st_nxt.slot_cnt[t][s] == '0 &&
					!(st_nxt.rd_pend[st_nxt.slot_own[t][s]] &&
					st_nxt.rd_tgt[st_nxt.slot_own[t][s]] == ID_W'(t)))
					st_nxt.slot_vld[t][s] = 1'b0;
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// ------------------------------------------------------------------
	// outputs, all straight from the state register
	// ------------------------------------------------------------------
	assign o_req_ack = st_r.ack;
	assign o_rsp_valid = st_r.rsp_vld;
	assign o_rsp_rdata = st_r.rsp_dat;

	for (genvar g = 0; g < NUM_PORTS; g++)
	begin : g_tgt
		assign o_tgt_valid[g] = st_r.fifo_vld[g][0];
		assign o_tgt_write[g] = st_r.fifo_ent[g][0].write;
		assign o_tgt_src[g] = st_r.fifo_ent[g][0].src;
		assign o_tgt_words[g] = st_r.fifo_ent[g][0].words;
		assign o_tgt_addr[g] = st_r.fifo_ent[g][0].addr;
		assign o_tgt_wdata[g] = st_r.fifo_ent[g][0].data;
	end

endmodule // mgmt_crossbar

// >>> testbench/mgmt_crossbar_assertions.sv
// port checker for the management crossbar
// assumes it is bound to mgmt_crossbar on its one clock
`timescale 1ns/1ps
module mgmt_crossbar_assertions
	import mgmt_crossbar_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [NUM_PORTS-1:0] i_req_valid,
	input wire logic [NUM_PORTS-1:0] o_req_ack,
	input wire logic [NUM_PORTS-1:0] o_rsp_valid,
	input wire logic [NUM_PORTS-1:0] o_tgt_valid,
	input wire logic [NUM_PORTS-1:0][DW-1:0] o_tgt_addr,
	input wire logic [NUM_PORTS-1:0] i_tgt_ready,
	input wire logic [NUM_PORTS-1:0] i_tgt_rsp_valid,
	input wire logic [NUM_PORTS-1:0][ID_W-1:0] i_tgt_rsp_src
);
	// ----
	// properties
	// ----
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	property p_ack_pulse; (o_req_ack & $past(o_req_ack)) == '0; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack");
	property p_ack_cause; (o_req_ack & ~$past(i_req_valid)) == '0; endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("cause");
	property p_head; ($past(o_tgt_valid & ~i_tgt_ready) & ~o_tgt_valid) == '0;
	endproperty
	a_head: assert property (p_head) else $error("head lost");
	property p_addr; o_tgt_valid[3] && !i_tgt_ready[3] |=>
		$stable(o_tgt_addr[3]); endproperty
	a_addr: assert property (p_addr) else $error("head moved");
	property p_route; i_tgt_rsp_valid[3] && i_tgt_rsp_src[3] == 4'h5 |=>
		o_rsp_valid[5]; endproperty
	a_route: assert property (p_route) else $error("route");
	property p_count; !$past(i_reset) |->
		$countones(o_rsp_valid) == $past($countones(i_tgt_rsp_valid));
	endproperty
	a_count: assert property (p_count) else $error("rsp count");
	property p_quiet; $past(i_reset) |-> (o_req_ack | o_tgt_valid) == '0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("reset");
	property p_rsp_gap; (o_rsp_valid & $past(o_rsp_valid)) == '0; endproperty
	a_rsp_gap: assert property (p_rsp_gap) else $error("rsp gap");
	c_ack: cover property (|o_req_ack);
	c_rsp: cover property (|o_rsp_valid);
	c_stall: cover property (o_tgt_valid[5] && !i_tgt_ready[5]);
	c_limit: cover property (i_req_valid[4] && !o_req_ack[4]);
endmodule // mgmt_crossbar_assertions

bind mgmt_crossbar mgmt_crossbar_assertions u_chk (
	.i_core_clk(i_core_clk),
	.i_reset(i_reset),
	.i_req_valid(i_req_valid),
	.o_req_ack(o_req_ack),
	.o_rsp_valid(o_rsp_valid),
	.o_tgt_valid(o_tgt_valid),
	.o_tgt_addr(o_tgt_addr),
	.i_tgt_ready(i_tgt_ready),
	.i_tgt_rsp_valid(i_tgt_rsp_valid),
	.i_tgt_rsp_src(i_tgt_rsp_src)
);

// >>> testbench/mgmt_tgt_model.sv
// twelve target blocks: pop the queue head, answer reads with the address
// assumes the crossbar's target group ports; i_hold forces back pressure
`timescale 1ns/1ps
module mgmt_tgt_model
	import mgmt_crossbar_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_slow,
	input wire logic [NUM_PORTS-1:0] i_hold,
	input wire logic [NUM_PORTS-1:0] i_valid,
	input wire logic [NUM_PORTS-1:0] i_write,
	input wire logic [NUM_PORTS-1:0][ID_W-1:0] i_src,
	input wire logic [NUM_PORTS-1:0][DW-1:0] i_addr,
	output logic [NUM_PORTS-1:0] o_ready,
	output logic [NUM_PORTS-1:0] o_rsp_valid,
	output logic [NUM_PORTS-1:0][ID_W-1:0] o_rsp_src,
	output logic [NUM_PORTS-1:0][WIDE_W-1:0] o_rsp_rdata
);
	logic ph_r;
	// slow mode pops only every other cycle
	assign o_ready = ~i_hold & {NUM_PORTS{~i_slow | ph_r}};
	always_ff @(posedge i_core_clk)
	begin
		ph_r <= ~ph_r & ~i_reset;
		for (int t = 0; t < NUM_PORTS; t++)
		begin
			// reads answered in pop order, writes never
			o_rsp_valid[t] <= ~i_reset & i_valid[t] & o_ready[t] &
				~i_write[t];
			o_rsp_src[t] <= i_src[t];
			// idle data lines flip so stale data never looks valid
			if (i_reset)
				o_rsp_rdata[t] <= '0;
			else if (i_valid[t] & o_ready[t])
				o_rsp_rdata[t] <= {WIDE_WORDS{i_addr[t]}};
			else
				o_rsp_rdata[t] <= ~o_rsp_rdata[t];
		end
	end
endmodule // mgmt_tgt_model

// >>> testbench/test_mgmt_crossbar.sv
// self-checking bench for the management crossbar
// assumes the target model and the bound port checker
`timescale 1ns/1ps
module test_mgmt_crossbar import mgmt_crossbar_pkg::*;;
	logic i_core_clk = 0, i_reset = 1, slow = 0;
	logic [NUM_PORTS-1:0] i_req_valid = '0, i_req_write = '0, i_req_last = '0;
	logic [NUM_PORTS-1:0] hold = '0, o_req_ack, o_rsp_valid, o_tgt_valid;
	logic [NUM_PORTS-1:0] o_tgt_write, i_tgt_ready, i_tgt_rsp_valid;
	logic [NUM_PORTS-1:0][ID_W-1:0] i_req_tgt = '0, o_tgt_src, i_tgt_rsp_src;
	logic [NUM_PORTS-1:0][DW-1:0] i_req_addr = '0, i_req_wdata = '0, o_tgt_addr;
	logic [NUM_PORTS-1:0][WIDE_W-1:0] o_rsp_rdata, o_tgt_wdata, i_tgt_rsp_rdata;
	logic [NUM_PORTS-1:0][CNT_W-1:0] o_tgt_words;
	// row: initiator, target, write, address
	logic [DW-1:0] rows [8][4] = '{'{5,3,1,'h31}, '{5,3,0,'h32}, '{1,0,1,'h41},
		'{11,0,0,'h42}, '{2,6,0,'h61}, '{3,11,1,'h71}, '{5,3,0,'h33}, '{0,6,1,'h62}};
	int n_errors = 0, comparisons = 0, n, m;
	mgmt_crossbar DUT (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_req_valid(i_req_valid),
		.i_req_write(i_req_write),
		.i_req_last(i_req_last),
		.i_req_tgt(i_req_tgt),
		.i_req_addr(i_req_addr),
		.i_req_wdata(i_req_wdata),
		.o_req_ack(o_req_ack),
		.o_rsp_valid(o_rsp_valid),
		.o_rsp_rdata(o_rsp_rdata),
		.o_tgt_valid(o_tgt_valid),
		.o_tgt_write(o_tgt_write),
		.o_tgt_src(o_tgt_src),
		.o_tgt_words(o_tgt_words),
		.o_tgt_addr(o_tgt_addr),
		.o_tgt_wdata(o_tgt_wdata),
		.i_tgt_ready(i_tgt_ready),
		.i_tgt_rsp_valid(i_tgt_rsp_valid),
		.i_tgt_rsp_src(i_tgt_rsp_src),
		.i_tgt_rsp_rdata(i_tgt_rsp_rdata)
	);
	mgmt_tgt_model u_tgt (.i_core_clk, .i_reset, .i_slow(slow), .i_hold(hold),
		.i_valid(o_tgt_valid), .i_write(o_tgt_write), .i_src(o_tgt_src),
		.i_addr(o_tgt_addr), .o_ready(i_tgt_ready), .o_rsp_valid(i_tgt_rsp_valid),
		.o_rsp_src(i_tgt_rsp_src), .o_rsp_rdata(i_tgt_rsp_rdata));
	always #4 i_core_clk = ~i_core_clk;
	// ----
	// tasks
	// ----
	task chk(input logic [WIDE_W-1:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one word; held until the ack is seen, then read data is awaited
	task automatic req(input int i, t, w, l, input logic [DW-1:0] a, output int k);
		@(negedge i_core_clk);
		i_req_valid[i] = 1;
		i_req_write[i] = w[0];
		i_req_last[i] = l[0];
		i_req_tgt[i] = t[ID_W-1:0];
		i_req_addr[i] = a;
		i_req_wdata[i] = a ^ 32'hd000_0000;
		k = 0;
		while (o_req_ack[i] !== 1'b1 && k < 60)
			@(posedge i_core_clk) #1 k++;
		chk(k < 60, 1);
		@(negedge i_core_clk);
		i_req_valid[i] = 0;
		for (int j = 0; j < 60 && !w && o_rsp_valid[i] !== 1'b1; j++)
			@(posedge i_core_clk) #1;
		if (!w)
		begin
			chk(o_rsp_valid[i], 1);
			chk(o_rsp_rdata[i], {WIDE_WORDS{a}});
			// hand back on a falling edge so the caller drives from there
			@(negedge i_core_clk);
		end
	endtask
	// ----
	// sequence; the watchdog allows well over a hundred times the expected run
	// ----
	initial
	begin
		repeat (20000) @(posedge i_core_clk);
		n_errors++;
		give_verdict;
	end
	initial
	begin
		repeat (10) @(negedge i_core_clk);
		chk({o_req_ack, o_rsp_valid, o_tgt_valid}, '0);
		i_reset = 0;
		foreach (rows[r])
		begin
			slow = r > 3;
			req(rows[r][0], rows[r][1], rows[r][2], 1, rows[r][3],
				n);
		end
		// four words to a held target leave as one queue entry
		hold[3] = 1;
		for (int k = 0; k < 4; k++)
			req(2, 3, 1, k == 3, 32'h0000_0020 + k, n);
		chk({o_tgt_valid[3], o_tgt_write[3], o_tgt_src[3], o_tgt_words[3],
			o_tgt_addr[3]},
			{1'b1, 1'b1, 4'h2, 2'h3, 32'h0000_0023});
		chk(o_tgt_wdata[3],
			128'hd000_0023_d000_0022_d000_0021_d000_0020);
		hold = 12'h020;
		req(1, 5, 1, 1, 32'h0000_0051, n);
		req(2, 5, 1, 1, 32'h0000_0052, n);
		fork
			req(3, 5, 1, 1, 32'h0000_0053, n);
			begin
				repeat (12) @(negedge i_core_clk);
				hold = '0;
			end
		join
		chk(n > 10, 1);
		fork
			req(4, 7, 0, 1, 32'h0000_0074, n);
			req(7, 4, 0, 1, 32'h0000_0047, n);
			req(8, 9, 0, 1, 32'h0000_0098, n);
			req(9, 9, 0, 1, 32'h0000_0099, n);
		join
		// three initiators park partial words at the rate monitor target,
		// so a fourth gets no scratch set until one of them commits
		for (int k = 1; k < 4; k++)
			req(k, RATE_MON_PORT, 1, 0, 32'h0000_1000 + k, n);
		fork
			req(4, RATE_MON_PORT, 1, 0, 32'h0000_1004, n);
			begin
				repeat (12) @(negedge i_core_clk);
				req(1, RATE_MON_PORT, 1, 1, 32'h0000_1005, m);
			end
		join
		chk(n > 10, 1);
		chk(m < 3, 1);
		i_reset = 1;
		repeat (3) @(negedge i_core_clk);
		chk({o_req_ack, o_rsp_valid, o_tgt_valid}, '0);
		chk(o_rsp_rdata[9] | o_tgt_wdata[3], '0);
		i_reset = 0;
		req(10, 2, 0, 1, 32'h0000_0102, n);
		give_verdict;
	end
endmodule // test_mgmt_crossbar
